/* hw/ccsw_ctrl.sv */
module ccsw_ctrl
	import ccsw_pkg::*;
#(
	parameter int F_INT_HS_HZ = F_INT_HS_DEF,
	parameter int F_EXT_HS_HZ = F_EXT_HS_DEF,
	parameter int F_SUB_HZ    = F_SUB_DEF,
	parameter int CNT_W       = CNT_W_DEF
)(
	input  wire logic        mclk_in,
	input  wire logic        srst_in,
	input  wire logic        wb_cyc_in,
	input  wire logic        wb_stb_in,
	input  wire logic        wb_we_in,
	input  wire logic [3:0]  wb_adr_in,
	input  wire logic [3:0]  wb_sel_in,
	input  wire logic [31:0] wb_dat_in,
	output logic [31:0]      wb_dat_out,
	output logic             wb_ack_out,
	input  wire logic        int_hs_tick_in,
	input  wire logic        ext_hs_tick_in,
	input  wire logic        sub_tick_in,
	input  wire logic        int_ls_tick_in,
	input  wire logic        periph_pin_tick_in,
	output logic             cpu_tick_out,
	output logic             periph_tick_out,
	output logic             wdt_tick_out,
	output logic             rtc_tick_out,
	output logic             adc_tick_out,
	output logic             timer_tick_out,
	output logic             cpu_source_status_out,
	output logic             main_source_status_out,
	output logic             int_hs_osc_stop_out,
	output logic             ext_main_osc_stop_out,
	output logic             sub_osc_select_out,
	output logic             ext_hs_clock_enable_out
);
	logic [2:0]       div_tgt;
	logic [2:0]       div_eff;
	logic [2:0]       pend_div;
	logic             css_tgt;
	logic             pend_css;
	logic             cpu_source_status;
	logic             main_source_sel;
	logic             main_source_status;
	logic             pend_main;
	logic             ext_hs_clock_enable;
	logic             ext_en_locked;
	logic             int_hs_osc_stop;
	logic             ext_main_osc_stop;
	logic             sub_osc_select;
	logic             timer_pin_sel;
	logic [CNT_W-1:0] pend_clks;
	logic [CNT_W-1:0] ticks_seen;
	logic             main_cpu_tick;
	logic             cpu_busy;
	logic             cpu_done;
	logic             main_busy;
	logic             main_done;

	// Bus slave: ack one cycle after the request, writes land on ack
	wire req    = wb_cyc_in & wb_stb_in;
	wire wr_en  = req & wb_ack_out & wb_we_in & wb_sel_in[0];
	wire wr_pro = wr_en & (wb_adr_in == ADR_PROC_CLK);
	wire wr_mm  = wr_en & (wb_adr_in == ADR_MAIN_MODE);
	wire wr_osc = wr_en & (wb_adr_in == ADR_OSC_CTRL);
	wire wr_per = wr_en & (wb_adr_in == ADR_PERIPH_SRC);
	wire [2:0] wr_div = (wb_dat_in[BIT_DIV_MSB:0] > DIV_MAX) ?
		DIV_MAX : wb_dat_in[BIT_DIV_MSB:0];

	wire [7:0] rd_pro = {2'h0, cpu_source_status, css_tgt, 1'b0,
		div_tgt};
	wire [7:0] rd_mm  = {5'h0, ext_hs_clock_enable, main_source_status,
		main_source_sel};
	wire [7:0] rd_osc = {5'h0, sub_osc_select, ext_main_osc_stop,
		int_hs_osc_stop};
	wire [7:0] rd_per = {7'h0, timer_pin_sel};
	wire [7:0] rd_val =
		(wb_adr_in == ADR_PROC_CLK)   ? rd_pro :
		(wb_adr_in == ADR_MAIN_MODE)  ? rd_mm  :
		(wb_adr_in == ADR_OSC_CTRL)   ? rd_osc :
		(wb_adr_in == ADR_PERIPH_SRC) ? rd_per : 8'h00;

	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
		begin
			wb_ack_out <= 1'b0;
			wb_dat_out <= 32'h0000_0000;
		end
		else
		begin
			wb_ack_out <= req & ~wb_ack_out;
			if (req & ~wb_ack_out)
				wb_dat_out <= {24'h00_0000, rd_val};
		end
	end

	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
		begin
			div_tgt <= RST_DIV;
			css_tgt <= 1'b0;
		end
		else if (wr_pro)
		begin
			div_tgt <= wr_div;
			css_tgt <= wb_dat_in[BIT_CSS];
		end
	end

	// enable accepts its first change only
	wire ext_en_change = wr_mm & ~ext_en_locked &
		(wb_dat_in[BIT_EXT_EN] != ext_hs_clock_enable);

	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
		begin
			main_source_sel     <= 1'b0;
			ext_hs_clock_enable <= 1'b0;
			ext_en_locked       <= 1'b0;
		end
		else
		begin
			if (wr_mm)
				main_source_sel <= wb_dat_in[BIT_MAIN_SEL];
			if (ext_en_change)
			begin
				ext_hs_clock_enable <= wb_dat_in[BIT_EXT_EN];
				ext_en_locked       <= 1'b1;
			end
		end
	end

	// Stop requests are passed on as written; software owns the checks
	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
		begin
			int_hs_osc_stop   <= RST_INT_STOP;
			ext_main_osc_stop <= RST_EXT_STOP;
			sub_osc_select    <= RST_SUB_SEL;
			timer_pin_sel     <= 1'b0;
		end
		else
		begin
			if (wr_osc)
			begin
				int_hs_osc_stop   <= wb_dat_in[BIT_INT_STOP];
				ext_main_osc_stop <= wb_dat_in[BIT_EXT_STOP];
				sub_osc_select    <= wb_dat_in[BIT_SUB_SEL];
			end
			if (wr_per)
				timer_pin_sel <= wb_dat_in[BIT_TMR_PIN];
		end
	end

	// Clock trees, modelled as one-cycle ticks of each source
	wire main_tick = main_source_status ? ext_hs_tick_in : int_hs_tick_in;

	ccsw_tick_div u_div (
		.mclk_in  (mclk_in),
		.srst_in  (srst_in),
		.tick_in  (main_tick),
		.div_in   (div_eff),
		.tick_out (main_cpu_tick)
	);

	// status and mux share one select, so they move together
	wire cpu_tick = cpu_source_status ? sub_tick_in : main_cpu_tick;

	// CPU source and divider switchover
	wire cpu_start = ~cpu_busy & ((div_tgt != div_eff) |
		(css_tgt != cpu_source_status));
	wire [CNT_W-1:0] cpu_clks = CNT_W'(cpu_switch_clks(cpu_source_status,
		div_eff, css_tgt, main_source_status ? F_EXT_HS_HZ : F_INT_HS_HZ,
		F_SUB_HZ));

	// count old CPU clocks before moving
	ccsw_delay_cnt #(.CNT_W(CNT_W)) u_cpu_dly (
		.mclk_in  (mclk_in),
		.srst_in  (srst_in),
		.load_in  (cpu_start),
		.count_in (cpu_clks),
		.tick_in  (cpu_tick),
		.busy_out (cpu_busy),
		.done_out (cpu_done)
	);

	// Switch lands on an old-clock tick, so no runt cycle reaches the CPU
	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
		begin
			div_eff           <= RST_DIV;
			cpu_source_status <= 1'b0;
			pend_div          <= RST_DIV;
			pend_css          <= 1'b0;
			pend_clks         <= '0;
		end
		else if (cpu_start)
		begin
			pend_div  <= div_tgt;
			pend_css  <= css_tgt;
			pend_clks <= cpu_clks;
		end
		// status updated as new clock takes over
		else if (cpu_done)
		begin
			div_eff           <= pend_div;
			cpu_source_status <= pend_css;
		end
	end

	// Main source switchover; a move to external is held back until the external clock is on
	wire main_allowed = ~main_source_sel |
		(ext_hs_clock_enable & ~ext_main_osc_stop);
	wire main_start = ~main_busy & main_allowed &
		(main_source_sel != main_source_status);
	// truncated bound in old main clocks
	wire [CNT_W-1:0] main_clks = main_source_status ?
		CNT_W'(main_switch_clks(F_EXT_HS_HZ, F_INT_HS_HZ)) :
		CNT_W'(main_switch_clks(F_INT_HS_HZ, F_EXT_HS_HZ));

	ccsw_delay_cnt #(.CNT_W(CNT_W)) u_main_dly (
		.mclk_in  (mclk_in),
		.srst_in  (srst_in),
		.load_in  (main_start),
		.count_in (main_clks),
		.tick_in  (main_tick),
		.busy_out (main_busy),
		.done_out (main_done)
	);

	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
		begin
			main_source_status <= 1'b0;
			pend_main          <= 1'b0;
		end
		else if (main_start)
			pend_main <= main_source_sel;
		else if (main_done)
			main_source_status <= pend_main;
	end

	// each consumer sees only its permitted source
	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
		begin
			cpu_tick_out    <= 1'b0;
			periph_tick_out <= 1'b0;
			wdt_tick_out    <= 1'b0;
			rtc_tick_out    <= 1'b0;
			adc_tick_out    <= 1'b0;
			timer_tick_out  <= 1'b0;
		end
		else
		begin
			cpu_tick_out    <= cpu_tick;
			periph_tick_out <= main_tick;
			wdt_tick_out    <= int_ls_tick_in;
			rtc_tick_out    <= sub_tick_in;
			adc_tick_out    <= cpu_tick;
			timer_tick_out  <= timer_pin_sel ? periph_pin_tick_in :
				main_tick;
		end
	end

	assign cpu_source_status_out   = cpu_source_status;
	assign main_source_status_out  = main_source_status;
	assign int_hs_osc_stop_out     = int_hs_osc_stop;
	assign ext_main_osc_stop_out   = ext_main_osc_stop;
	assign sub_osc_select_out      = sub_osc_select;
	assign ext_hs_clock_enable_out = ext_hs_clock_enable;

	// Helper: old-clock ticks seen during a CPU switch
	always_ff @(posedge mclk_in)
	begin
		if (srst_in | cpu_start)
			ticks_seen <= '0;
		else if (cpu_busy & cpu_tick)
			ticks_seen <= ticks_seen + CNT_W'(1);
	end

	AST_CPU_DELAY_COUNT: assert property (@(posedge mclk_in)
		disable iff (srst_in)
		cpu_done |-> ticks_seen + CNT_W'(1) == pend_clks)
		else $error("CPU switch ended after wrong tick count");

	AST_MAIN_TO_SUB_RATIO: assert property (@(posedge mclk_in)
		disable iff (srst_in)
		cpu_start && !cpu_source_status && css_tgt |=>
		pend_clks == CNT_W'((2 * (main_source_status ? F_EXT_HS_HZ :
		F_INT_HS_HZ) + (F_SUB_HZ << div_eff) - 1) /
		(F_SUB_HZ << div_eff)))
		else $error("Main to sub delay not rounded up ratio");

	AST_OLD_CLOCK_HOLDS: assert property (@(posedge mclk_in)
		disable iff (srst_in)
		cpu_busy && !cpu_done |=> $stable(cpu_source_status) &&
		$stable(div_eff))
		else $error("CPU clock moved before delay elapsed");

	AST_STATUS_WITH_CLOCK: assert property (@(posedge mclk_in)
		disable iff (srst_in)
		$changed(cpu_source_status) |-> $past(cpu_done) && $past(cpu_tick))
		else $error("CPU status moved off an old clock edge");

	AST_SUB_TO_MAIN_DIV: assert property (@(posedge mclk_in)
		disable iff (srst_in)
		cpu_done && cpu_source_status && !pend_css |=>
		!cpu_source_status && div_eff == $past(pend_div))
		else $error("Divider lost on return to main clock");

	AST_MAIN_SWITCH_BOUND: assert property (@(posedge mclk_in)
		disable iff (srst_in)
		main_start && !main_source_status |->
		main_clks == CNT_W'(1 + (2 * F_INT_HS_HZ) / F_EXT_HS_HZ))
		else $error("Main switch bound miscounted");

	AST_MAIN_STATUS_CAUSE: assert property (@(posedge mclk_in)
		disable iff (srst_in)
		$changed(main_source_status) |-> $past(main_done) &&
		main_source_status == $past(pend_main))
		else $error("Main status changed without a switch");

	AST_EXT_NEEDS_ENABLE: assert property (@(posedge mclk_in)
		disable iff (srst_in)
		main_source_status |-> ext_hs_clock_enable)
		else $error("External main clock active while disabled");

	AST_ENABLE_ONCE: assert property (@(posedge mclk_in)
		disable iff (srst_in)
		$past(ext_en_locked) |-> $stable(ext_hs_clock_enable))
		else $error("External enable changed twice");

	AST_CPU_STATUS_READ: assert property (@(posedge mclk_in)
		disable iff (srst_in)
		req && !wb_ack_out && !wb_we_in && wb_adr_in == ADR_PROC_CLK |=>
		wb_dat_out[BIT_CPU_STAT] == $past(cpu_source_status))
		else $error("CPU status bit misread");

	AST_WDT_SOURCE: assert property (@(posedge mclk_in)
		disable iff (srst_in)
		!$past(srst_in) |-> wdt_tick_out == $past(int_ls_tick_in) &&
		rtc_tick_out == $past(sub_tick_in))
		else $error("Peripheral fed from a forbidden source");

	COV_MAIN_TO_SUB: cover property (@(posedge mclk_in)
		disable iff (srst_in) $rose(cpu_source_status));
	COV_SUB_TO_MAIN: cover property (@(posedge mclk_in)
		disable iff (srst_in) $fell(cpu_source_status));
	COV_MAIN_TO_EXT: cover property (@(posedge mclk_in)
		disable iff (srst_in) $rose(main_source_status));
	COV_DIV_CHANGE: cover property (@(posedge mclk_in)
		disable iff (srst_in) $changed(div_eff) && !cpu_source_status);
endmodule

/* hw/ccsw_delay_cnt.sv */
module ccsw_delay_cnt
	import ccsw_pkg::*;
#(
	parameter int CNT_W = CNT_W_DEF
)(
	input  wire logic             mclk_in,
	input  wire logic             srst_in,
	input  wire logic             load_in,
	input  wire logic [CNT_W-1:0] count_in,
	input  wire logic             tick_in,
	output logic                  busy_out,
	output logic                  done_out
);
	logic [CNT_W-1:0] remain;
	// A zero count would wrap and last 2^CNT_W ticks, so it runs as one
	wire  [CNT_W-1:0] next_remain =
		(count_in == '0) ? CNT_W'(1) : count_in;

	assign done_out = busy_out & tick_in & (remain == CNT_W'(1));

	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
		begin
			busy_out <= 1'b0;
			remain   <= '0;
		end
		else if (load_in)
		begin
			busy_out <= 1'b1;
			remain   <= next_remain;
		end
		else if (done_out)
			busy_out <= 1'b0;
		else if (busy_out & tick_in)
			remain <= remain - CNT_W'(1);
	end
endmodule

/* hw/ccsw_pkg.sv */
// Operation
// - Div change allowed with sub-to-main move
// - Delay counted in pre-switch CPU clocks
// - Main-to-sub delay is twice ratio rounded up
// - Main select bit0: internal or external
// - Old clock runs until delay elapses
// - Main status bit1 shows active source
// - Main switch takes one plus twice ratio
// - Main delay in old clocks, truncated
// - External enable changes once per reset
// - Peripherals get only permitted clock sources
// - Div bits 0-2, source select bit 4
// - CPU status bit5 shows main or sub
package ccsw_pkg;

	localparam logic [3:0] ADR_PROC_CLK   = 4'h0;
	localparam logic [3:0] ADR_MAIN_MODE  = 4'h4;
	localparam logic [3:0] ADR_OSC_CTRL   = 4'h8;
	localparam logic [3:0] ADR_PERIPH_SRC = 4'hc;

	localparam int BIT_DIV_MSB   = 2;
	localparam int BIT_CSS       = 4;
	localparam int BIT_CPU_STAT  = 5;
	localparam int BIT_MAIN_SEL  = 0;
	localparam int BIT_MAIN_STAT = 1;
	localparam int BIT_EXT_EN    = 2;
	localparam int BIT_INT_STOP  = 0;
	localparam int BIT_EXT_STOP  = 1;
	localparam int BIT_SUB_SEL   = 2;
	localparam int BIT_TMR_PIN   = 0;

	localparam logic [2:0] RST_DIV      = 3'h0;
	localparam logic       RST_INT_STOP = 1'b0;
	localparam logic       RST_EXT_STOP = 1'b1;
	localparam logic       RST_SUB_SEL  = 1'b0;
	localparam logic [2:0] DIV_MAX      = 3'h4;

	localparam int SUB_TO_MAIN_CLKS = 2;
	localparam int DIV_SWITCH_BASE  = 16;
	localparam int F_INT_HS_DEF     = 8000000;
	localparam int F_EXT_HS_DEF     = 10000000;
	localparam int F_SUB_DEF        = 32768;
	localparam int CNT_W_DEF        = 16;

	// CPU source or divider switch, in pre-switch CPU clocks
	function automatic int cpu_switch_clks(input logic old_css,
		input logic [2:0] old_div, input logic new_css,
		input int f_main, input int f_sub);
		int den;
		den = f_sub << old_div;
		if (old_css)
			return SUB_TO_MAIN_CLKS;
		else if (new_css)
			return (2 * f_main + den - 1) / den;
		else
			return DIV_SWITCH_BASE >> old_div;
	endfunction

	// Main source switch, in old main clocks, fraction dropped
	function automatic int main_switch_clks(input int f_old,
		input int f_new);
		return 1 + (2 * f_old) / f_new;
	endfunction

endpackage

/* hw/ccsw_tick_div.sv */
module ccsw_tick_div
	import ccsw_pkg::*;
(
	input  wire logic       mclk_in,
	input  wire logic       srst_in,
	input  wire logic       tick_in,
	input  wire logic [2:0] div_in,
	output logic            tick_out
);
	logic [3:0] cnt;
	wire  [3:0] limit = 4'((5'h1 << div_in) - 5'h1);

	assign tick_out = tick_in & (cnt >= limit);

	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
			cnt <= 4'h0;
		else if (tick_in)
			cnt <= (cnt >= limit) ? 4'h0 : cnt + 4'h1;
	end
endmodule

/* testbench/ccsw_ctrl_bench.sv */
`define CHK(what, exp, got) \
	begin \
		n_compared++; \
		if ((got) !== (exp)) \
		begin \
			n_mismatch++; \
			$display("Error %s expected %h seen %h", what, exp, got); \
		end \
	end

module ccsw_ctrl_bench;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int F_INT  = ccsw_pkg::F_INT_HS_DEF;
	localparam int F_EXT  = ccsw_pkg::F_EXT_HS_DEF;
	localparam int F_SUB  = ccsw_pkg::F_SUB_DEF;
	localparam int M2S    = (2 * F_INT + F_SUB - 1) / F_SUB;
	localparam int I2E    = 1 + (2 * F_INT) / F_EXT;
	localparam int E2I    = 1 + (2 * F_EXT) / F_INT;

	logic        mclk_in;
	logic        srst_in;
	logic        cyc;
	logic        stb;
	logic        we;
	logic [3:0]  adr;
	logic [3:0]  sel;
	logic [31:0] wdat;
	logic [31:0] wb_dat_out;
	logic        wb_ack_out;
	logic        t_int;
	logic        t_ext;
	logic        t_sub;
	logic        t_ls;
	logic        t_pin;
	logic        cpu_tick_out;
	logic        periph_tick_out;
	logic        wdt_tick_out;
	logic        rtc_tick_out;
	logic        adc_tick_out;
	logic        timer_tick_out;
	logic        cpu_source_status_out;
	logic        main_source_status_out;
	logic        int_hs_osc_stop_out;
	logic        ext_main_osc_stop_out;
	logic        sub_osc_select_out;
	logic        ext_hs_clock_enable_out;
	int          n_mismatch;
	int          n_compared;
	int          cyc_cnt;

	ccsw_ctrl #(.F_INT_HS_HZ(F_INT), .F_EXT_HS_HZ(F_EXT), .F_SUB_HZ(F_SUB),
		.CNT_W(16)) ccsw_ctrl_inst (
		.mclk_in(mclk_in), .srst_in(srst_in), .wb_cyc_in(cyc),
		.wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel),
		.wb_dat_in(wdat), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
		.int_hs_tick_in(t_int), .ext_hs_tick_in(t_ext), .sub_tick_in(t_sub),
		.int_ls_tick_in(t_ls), .periph_pin_tick_in(t_pin),
		.cpu_tick_out(cpu_tick_out), .periph_tick_out(periph_tick_out),
		.wdt_tick_out(wdt_tick_out), .rtc_tick_out(rtc_tick_out),
		.adc_tick_out(adc_tick_out), .timer_tick_out(timer_tick_out),
		.cpu_source_status_out(cpu_source_status_out),
		.main_source_status_out(main_source_status_out),
		.int_hs_osc_stop_out(int_hs_osc_stop_out),
		.ext_main_osc_stop_out(ext_main_osc_stop_out),
		.sub_osc_select_out(sub_osc_select_out),
		.ext_hs_clock_enable_out(ext_hs_clock_enable_out));

	initial
	begin
		mclk_in = 1'b0;
		forever #12.5 mclk_in = ~mclk_in;
	end

	// Source ticks at fixed, mutually skewed rates
	always @(posedge mclk_in)
	begin
		cyc_cnt <= cyc_cnt + 1;
		t_int <= (cyc_cnt % 2) == 0;
		t_ext <= (cyc_cnt % 2) == 1;
		t_sub <= (cyc_cnt % 8) == 3;
		t_ls <= (cyc_cnt % 4) == 1;
		t_pin <= (cyc_cnt % 3) == 2;
	end

	task automatic finish_test();
		if (n_mismatch == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic wb(input logic w, input logic [3:0] a,
		input logic [3:0] s, input logic [31:0] d, output logic [31:0] rd);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= s;
		wdat <= d;
		do
			@(posedge mclk_in);
		while (wb_ack_out !== 1'b1 && ++n < 50);
		`CHK("bus ack", 1'b1, wb_ack_out)
		rd = wb_dat_out;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge mclk_in);
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		logic [31:0] rd;
		wb(1'b1, a, 4'h1, {24'h0, d}, rd);
	endtask

	task automatic rdchk(input string what, input logic [3:0] a,
		input logic [7:0] e);
		logic [31:0] rd;
		wb(1'b0, a, 4'hf, 32'h0, rd);
		`CHK(what, {24'h0, e}, rd)
	endtask

	// Old-clock ticks from switch start until the status moves; tick
	// outputs lag one edge, so the first edge after release is skipped
	// and the edge that shows the new status still counts
	task automatic wait_sw(input bit on_cpu, input logic lvl, input int e);
		logic st;
		int   ticks;
		ticks = 0;
		@(posedge mclk_in);
		for (int n = 0; n < 3000; n++)
		begin
			@(posedge mclk_in);
			st = on_cpu ? cpu_source_status_out : main_source_status_out;
			if ((on_cpu ? cpu_tick_out : periph_tick_out) === 1'b1)
				ticks++;
			if (st === lvl)
				break;
		end
		`CHK("switch status", lvl, st)
		`CHK("switch delay", e, ticks)
	endtask

	task automatic t_reset();
		rdchk("proc clock reg", 4'h0, 8'h00);
		rdchk("main mode reg", 4'h4, 8'h00);
		rdchk("osc ctrl reg", 4'h8, 8'h02);
		rdchk("unmapped reg", 4'h2, 8'h00);
		`CHK("ext stop", 1'b1, ext_main_osc_stop_out)
		`CHK("ext enable", 1'b0, ext_hs_clock_enable_out)
	endtask

	task automatic t_regs();
		logic [31:0] rd;
		wb(1'b1, 4'h8, 4'h0, 32'h7, rd);
		rdchk("osc reg no sel", 4'h8, 8'h02);
		wr(4'h8, 8'h04);
		rdchk("osc reg", 4'h8, 8'h04);
		`CHK("sub select", 1'b1, sub_osc_select_out)
		`CHK("ext stop off", 1'b0, ext_main_osc_stop_out)
		// Pin clock chosen while high-speed clocks run
		wr(4'hc, 8'h01);
		rdchk("periph src reg", 4'hc, 8'h01);
		wr(4'h0, 8'h07);
		rdchk("div clamp", 4'h0, 8'h04);
		repeat (200) @(posedge mclk_in);
		wr(4'h0, 8'h00);
		repeat (200) @(posedge mclk_in);
	endtask

	task automatic t_main();
		// External enable set before selecting the external clock
		wr(4'h4, 8'h04);
		// Main select written while the CPU is on main
		wr(4'h4, 8'h05);
		wait_sw(1'b0, 1'b1, I2E);
		rdchk("main on ext", 4'h4, 8'h07);
		wr(4'h4, 8'h01);
		rdchk("enable locked", 4'h4, 8'h07);
		// Internal oscillator stopped only while unused
		wr(4'h8, 8'h05);
		`CHK("int stop", 1'b1, int_hs_osc_stop_out)
		wr(4'h8, 8'h04);
		wr(4'h4, 8'h04);
		wait_sw(1'b0, 1'b0, E2I);
		rdchk("main on int", 4'h4, 8'h04);
		wr(4'h8, 8'h06);
		`CHK("ext stopped", 1'b1, ext_main_osc_stop_out)
	endtask

	task automatic t_cpu();
		// Source move alone, divider untouched
		wr(4'h0, 8'h10);
		wait_sw(1'b1, 1'b1, M2S);
		rdchk("cpu on sub", 4'h0, 8'h30);
		wr(4'h0, 8'h02);
		wait_sw(1'b1, 1'b0, ccsw_pkg::SUB_TO_MAIN_CLKS);
		rdchk("back on main", 4'h0, 8'h02);
		// Sub oscillator dropped only once the CPU left it
		wr(4'h8, 8'h02);
		`CHK("sub deselect", 1'b0, sub_osc_select_out)
	endtask

	task automatic t_route();
		logic p_ls;
		logic p_sub;
		logic p_pin;
		@(posedge mclk_in);
		for (int n = 0; n < 48; n++)
		begin
			p_ls = t_ls;
			p_sub = t_sub;
			p_pin = t_pin;
			@(posedge mclk_in);
			`CHK("wdt tick", p_ls, wdt_tick_out)
			`CHK("rtc tick", p_sub, rtc_tick_out)
			// Both outputs are registered from the same CPU tick
			`CHK("adc tick", cpu_tick_out, adc_tick_out)
			`CHK("timer tick", p_pin, timer_tick_out)
		end
	endtask

	initial
	begin
		n_mismatch = 0;
		n_compared = 0;
		cyc_cnt = 0;
		srst_in = 1'b1;
		{cyc, stb, we, adr, sel, wdat} = '0;
		{t_int, t_ext, t_sub, t_ls, t_pin} = '0;
		repeat (16) @(posedge mclk_in);
		srst_in <= 1'b0;
		@(posedge mclk_in);
		t_reset();
		t_regs();
		t_main();
		t_cpu();
		t_route();
		finish_test();
	end

	// Whole sequence needs well under this many cycles
	initial
	begin
		repeat (20000) @(posedge mclk_in);
		n_mismatch++;
		finish_test();
	end
endmodule
